/* dcr_pkg.sv */
// Package of constants for the dual channel register pointer access block.
package dcr_pkg;
  localparam int PTR_W = 3;
  localparam logic [2:0] PTR_ZERO = 3'h0;
  localparam logic [2:0] REG_CMD = 3'h0;
  localparam logic [2:0] REG_ITM = 3'h1;
  localparam logic [2:0] REG_VEC = 3'h2;
  localparam logic [2:0] REG_RXP = 3'h3;
  localparam logic [2:0] REG_MISC = 3'h4;
  localparam logic [2:0] REG_TXP = 3'h5;
  localparam int NUM_WREG = 6;
  // Pointer field and command field of the command register.
  localparam int PTR_LSB = 0;
  localparam int CMD_LSB = 3;
  localparam int CMD_W = 3;
  localparam logic [2:0] CMD_NULL = 3'h0;
  localparam logic [2:0] CMD_CHAN_RESET = 3'h3;
  localparam logic [2:0] CMD_RET_INT = 3'h7;
  // Status affects vector bit in the interrupt mode register.
  localparam int SAV_BIT = 2;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] VEC_RESET = 8'h00;
  // Vector bits replaced when status affects the vector.
  localparam int VEC_MOD_LSB = 1;
  localparam int VEC_MOD_W = 3;
  // Code given when nothing is pending.
  localparam logic [2:0] VCODE_NONE = 3'h3;
  localparam logic [7:0] BUS_IDLE = 8'h00;
endpackage

/* dcr_regs.sv */
// Processor side register access and pointer logic for two channels.
`timescale 1ns/1ps

// Notes on behaviour
// [RULE1] Channel and control/data inputs route each transfer.
// [RULE2] Nonzero register loads take pointer then data.
// [RULE3] Commands act from a single command byte.
// [RULE4] Any reset clears the register pointer.
// [RULE5] Pointer in a reset byte is ignored.
// [RULE6] Vector write register exists in channel B only.
// [RULE7] Pointer byte selects next status read.
// [RULE8] Three read registers; vector read channel B.
// [RULE9] Read register one gathers receive errors.
// [RULE10] Read register zero shows buffer, interrupt, external.
// [RULE11] Host sets parameters, interrupts, then enables.
// [RULE12] Status affects vector alters read vector.
// [RULE13] Channel A return command clears service latch.
// [RULE14] Pointer returns to zero after one access.
module dcr_regs #(
  parameter int DATA_W = 8
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic chipEnableN,
  input wire logic readN,
  input wire logic ioReqN,
  input wire logic chanSelB,
  input wire logic ctrlSel,
  input wire logic [DATA_W-1:0] dataIn,
  output logic [DATA_W-1:0] dataOut,
  output logic dataOe,
  input wire logic [DATA_W-1:0] statusA,
  input wire logic [DATA_W-1:0] statusB,
  input wire logic [DATA_W-1:0] errorA,
  input wire logic [DATA_W-1:0] errorB,
  input wire logic [2:0] pendCode,
  input wire logic pendValid,
  output logic [DATA_W-1:0] itmA,
  output logic [DATA_W-1:0] itmB,
  output logic [DATA_W-1:0] rxParA,
  output logic [DATA_W-1:0] rxParB,
  output logic [DATA_W-1:0] miscA,
  output logic [DATA_W-1:0] miscB,
  output logic [DATA_W-1:0] txParA,
  output logic [DATA_W-1:0] txParB,
  output logic [DATA_W-1:0] vectorReg,
  output logic chanResetA,
  output logic chanResetB,
  output logic cmdStrobeA,
  output logic cmdStrobeB,
  output logic [2:0] cmdCode,
  output logic retIntCmd
);

  // Two flip-flop synchronisers on every pin input except the reset pin.
  logic [4:0] ctlMeta;
  logic [4:0] ctlSync;
  logic [DATA_W-1:0] dinMeta;
  logic [DATA_W-1:0] dinSync;
  logic [DATA_W-1:0] stAMeta, stASync, stBMeta, stBSync;
  logic [DATA_W-1:0] erAMeta, erASync, erBMeta, erBSync;
  logic [3:0] pendMeta, pendSync;

  // Synchroniser stages; the first stage feeds only the second.
  always_ff @(posedge mclk) begin
    ctlMeta <= {chipEnableN, readN, ioReqN, chanSelB, ctrlSel};
    ctlSync <= ctlMeta;
    dinMeta <= dataIn;
    dinSync <= dinMeta;
    stAMeta <= statusA;
    stASync <= stAMeta;
    stBMeta <= statusB;
    stBSync <= stBMeta;
    erAMeta <= errorA;
    erASync <= erAMeta;
    erBMeta <= errorB;
    erBSync <= erBMeta;
    pendMeta <= {pendValid, pendCode};
    pendSync <= pendMeta;
  end

  logic ceN, rdN, iorqN, selB, selCtl;
  assign {ceN, rdN, iorqN, selB, selCtl} = ctlSync;

  // A bus cycle is active while chip enable and request are low.
  logic cycAct, cycAct_reg;
  assign cycAct = !ceN && !iorqN;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cycAct_reg <= 1'b0;
    end else begin
      cycAct_reg <= cycAct;
    end
  end

  // One pulse at the start of each cycle, split by direction.
  logic cycStart, wrStb, rdStb;
  assign cycStart = cycAct && !cycAct_reg;
  assign wrStb = cycStart && rdN;
  assign rdStb = cycStart && !rdN;

  // Per channel pointers, chosen by the channel select.
  logic [2:0] ptrA_reg, ptrB_reg, ptrSel;
  assign ptrSel = selB ? ptrB_reg : ptrA_reg; // [RULE1]

  logic [2:0] wCmd;
  assign wCmd = dinSync[dcr_pkg::CMD_LSB +: dcr_pkg::CMD_W];

  // Decode a control write to the command register of one channel.
  // Every input is an argument, so the assignments follow each change.
  function automatic logic cmdWr(input logic stb, input logic ctl,
                                 input logic sB, input logic chB,
                                 input logic [2:0] ptr);
    cmdWr = stb && ctl && (sB == chB) && (ptr == dcr_pkg::REG_CMD);
  endfunction

  logic cmdWrA, cmdWrB;
  assign cmdWrA = cmdWr(wrStb, selCtl, selB, 1'b0, ptrA_reg);
  assign cmdWrB = cmdWr(wrStb, selCtl, selB, 1'b1, ptrB_reg);

  // Pointer update for one channel; returns to zero after one access.
  function automatic logic [2:0] ptrNext(input logic chB,
                                         input logic [2:0] ptr,
                                         input logic isCmd);
    logic ctlAcc;
    ctlAcc = (wrStb || rdStb) && selCtl && (selB == chB);
    ptrNext = ptr;
    if (isCmd) begin
      if (wCmd == dcr_pkg::CMD_CHAN_RESET) begin
        ptrNext = dcr_pkg::PTR_ZERO; // [RULE4] [RULE5]
      end else begin
        ptrNext = dinSync[dcr_pkg::PTR_LSB +: dcr_pkg::PTR_W]; // [RULE2] [RULE7]
      end
    end else if (ctlAcc) begin
      ptrNext = dcr_pkg::PTR_ZERO; // [RULE14]
    end
  endfunction

  // Register pointers cleared by the reset pin.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ptrA_reg <= dcr_pkg::PTR_ZERO; // [RULE4]
      ptrB_reg <= dcr_pkg::PTR_ZERO; // [RULE4]
    end else begin
      ptrA_reg <= ptrNext(1'b0, ptrA_reg, cmdWrA);
      ptrB_reg <= ptrNext(1'b1, ptrB_reg, cmdWrB);
    end
  end

  // Write strobe into a pointed register of one channel.
  logic wrDataA, wrDataB;
  assign wrDataA = wrStb && selCtl && !selB && (ptrA_reg != dcr_pkg::REG_CMD);
  assign wrDataB = wrStb && selCtl && selB && (ptrB_reg != dcr_pkg::REG_CMD);

  // Storage for the write registers of both channels.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      itmA <= dcr_pkg::BYTE_ZERO;
      itmB <= dcr_pkg::BYTE_ZERO;
      rxParA <= dcr_pkg::BYTE_ZERO;
      rxParB <= dcr_pkg::BYTE_ZERO;
      miscA <= dcr_pkg::BYTE_ZERO;
      miscB <= dcr_pkg::BYTE_ZERO;
      txParA <= dcr_pkg::BYTE_ZERO;
      txParB <= dcr_pkg::BYTE_ZERO;
      vectorReg <= dcr_pkg::VEC_RESET;
    end else begin
      if (wrDataA) begin
        case (ptrA_reg)
          dcr_pkg::REG_ITM: itmA <= dinSync; // [RULE2]
          dcr_pkg::REG_RXP: rxParA <= dinSync;
          dcr_pkg::REG_MISC: miscA <= dinSync;
          dcr_pkg::REG_TXP: txParA <= dinSync;
          default: ; // Vector register is absent in channel A.
        endcase
      end
      if (wrDataB) begin
        case (ptrB_reg)
          dcr_pkg::REG_ITM: itmB <= dinSync; // [RULE2]
          dcr_pkg::REG_VEC: vectorReg <= dinSync; // [RULE6]
          dcr_pkg::REG_RXP: rxParB <= dinSync;
          dcr_pkg::REG_MISC: miscB <= dinSync;
          dcr_pkg::REG_TXP: txParB <= dinSync;
          default: ;
        endcase
      end
    end
  end

  // Command strobes decoded from a single command byte.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cmdStrobeA <= 1'b0;
      cmdStrobeB <= 1'b0;
      chanResetA <= 1'b0;
      chanResetB <= 1'b0;
      retIntCmd <= 1'b0;
      cmdCode <= dcr_pkg::CMD_NULL;
    end else begin
      cmdStrobeA <= cmdWrA; // [RULE3]
      cmdStrobeB <= cmdWrB; // [RULE3]
      chanResetA <= cmdWrA && (wCmd == dcr_pkg::CMD_CHAN_RESET);
      chanResetB <= cmdWrB && (wCmd == dcr_pkg::CMD_CHAN_RESET);
      retIntCmd <= cmdWrA && (wCmd == dcr_pkg::CMD_RET_INT); // [RULE13]
      if (cmdWrA || cmdWrB) begin
        cmdCode <= wCmd;
      end
    end
  end

  // Modified vector: priority code replaces bits 3 to 1 when enabled.
  logic [DATA_W-1:0] modVec;
  always_comb begin
    modVec = vectorReg;
    if (itmB[dcr_pkg::SAV_BIT]) begin
      modVec[dcr_pkg::VEC_MOD_LSB +: dcr_pkg::VEC_MOD_W] =
        pendSync[3] ? pendSync[2:0] : dcr_pkg::VCODE_NONE; // [RULE12]
    end
  end

  // Read multiplexer for the status path; data reads give the idle byte.
  logic [DATA_W-1:0] rdSel;
  always_comb begin
    rdSel = dcr_pkg::BUS_IDLE;
    if (selCtl) begin
      case (ptrSel)
        dcr_pkg::REG_CMD: rdSel = selB ? stBSync : stASync; // [RULE10]
        dcr_pkg::REG_ITM: rdSel = selB ? erBSync : erASync; // [RULE9]
        dcr_pkg::REG_VEC: rdSel = selB ? modVec : dcr_pkg::BUS_IDLE; // [RULE8]
        default: rdSel = dcr_pkg::BUS_IDLE;
      endcase
    end
  end

  // Read data is captured at cycle start and driven while the read lasts.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      dataOut <= dcr_pkg::BUS_IDLE;
      dataOe <= 1'b0;
    end else begin
      if (rdStb) begin
        dataOut <= rdSel; // [RULE7]
      end
      dataOe <= cycAct && !rdN;
    end
  end

endmodule

/* dcr_regs_properties.sv */
// Checker of port relations for the register pointer block.
`timescale 1ns/1ps
module dcr_regs_chk (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic chipEnableN,
  input wire logic readN,
  input wire logic chanSelB,
  input wire logic ctrlSel,
  input wire logic [7:0] dataOut,
  input wire logic dataOe,
  input wire logic [7:0] itmA,
  input wire logic [7:0] vectorReg,
  input wire logic chanResetA,
  input wire logic cmdStrobeA,
  input wire logic cmdStrobeB,
  input wire logic retIntCmd
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  // A channel A reset comes with its command strobe and lasts one cycle.
  sequence s_rst_pulse;
    chanResetA && cmdStrobeA ##1 !chanResetA;
  endsequence
  property p_reset_cmd;
    $rose(chanResetA) |-> s_rst_pulse;
  endproperty
  property p_ret_int;
    retIntCmd |-> cmdStrobeA && !cmdStrobeB;
  endproperty
  property p_one_chan;
    !(cmdStrobeA && cmdStrobeB);
  endproperty
  property p_itm_write;
    $changed(itmA) |-> !chanSelB && ctrlSel && readN && !chipEnableN;
  endproperty
  property p_vec_chan;
    $changed(vectorReg) |-> chanSelB && ctrlSel && readN;
  endproperty
  property p_oe_read;
    $rose(dataOe) |-> !readN && !chipEnableN;
  endproperty
  property p_dout_hold;
    $changed(dataOut) |-> $rose(dataOe);
  endproperty
  property p_rst_zero;
    disable iff (1'b0) sys_rst |=> itmA == 8'h00 && vectorReg == 8'h00;
  endproperty
  a_reset_cmd: assert property (p_reset_cmd)
    else $error("reset pulse");
  a_ret_int: assert property (p_ret_int)
    else $error("return cmd");
  a_one_chan: assert property (p_one_chan)
    else $error("two strobes");
  a_itm_write: assert property (p_itm_write)
    else $error("itmA write");
  a_vec_chan: assert property (p_vec_chan)
    else $error("vector chan");
  a_oe_read: assert property (p_oe_read)
    else $error("oe rise");
  a_dout_hold: assert property (p_dout_hold)
    else $error("dout change");
  a_rst_zero: assert property (p_rst_zero)
    else $error("reset value");
endmodule
bind dcr_regs dcr_regs_chk i_dcr_regs_chk (
  .mclk(mclk), .sys_rst(sys_rst), .chipEnableN(chipEnableN),
  .readN(readN), .chanSelB(chanSelB), .ctrlSel(ctrlSel),
  .dataOut(dataOut), .dataOe(dataOe), .itmA(itmA),
  .vectorReg(vectorReg), .chanResetA(chanResetA),
  .cmdStrobeA(cmdStrobeA), .cmdStrobeB(cmdStrobeB),
  .retIntCmd(retIntCmd)
);

/* dcr_host.sv */
// Host processor model issuing control and data I/O cycles.
`timescale 1ns/1ps
module dcr_host (
  input wire logic mclk,
  output logic chipEnableN,
  output logic readN,
  output logic ioReqN,
  output logic chanSelB,
  output logic ctrlSel,
  output logic [7:0] dataIn,
  input wire logic [7:0] dataOut
);
  // Pins start idle; a released data line shows the inverse of its last value.
  initial begin
    chipEnableN = 1'b1;
    ioReqN = 1'b1;
    readN = 1'b1;
    chanSelB = 1'b0;
    ctrlSel = 1'b0;
    dataIn = 8'h00;
  end
  // One cycle held eight edges, then six idle edges before the next.
  task automatic cyc(input logic b, input logic c, input logic rd,
    input logic [7:0] d, output logic [7:0] q);
    @(posedge mclk);
    #1;
    chipEnableN = 1'b0;
    ioReqN = 1'b0;
    chanSelB = b;
    ctrlSel = c;
    readN = !rd;
    dataIn = rd ? ~dataIn : d;
    repeat (8) @(posedge mclk);
    q = dataOut;
    #1;
    chipEnableN = 1'b1;
    ioReqN = 1'b1;
    readN = 1'b1;
    dataIn = ~dataIn;
    repeat (6) @(posedge mclk);
  endtask
  // A pointer byte, then the byte stored in the pointed register.
  task automatic wreg(input logic b, input logic [2:0] r, input logic [7:0] d);
    logic [7:0] q;
    cyc(b, 1'b1, 1'b0, {5'h00, r}, q);
    cyc(b, 1'b1, 1'b0, d, q);
  endtask
endmodule

/* dcr_tb.sv */
// Self-checking bench for the register pointer block.
`timescale 1ns/1ps
module testbench;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic chipEnableN, readN, ioReqN, chanSelB, ctrlSel, dataOe;
  logic [7:0] dataIn, dataOut, q, itmA, itmB, rxParA, rxParB, miscA, miscB;
  logic [7:0] txParA, txParB, vectorReg, nRst = 8'h00, nRet = 8'h00;
  logic [7:0] statusA = 8'h5a, statusB = 8'hc3, errorA = 8'h21;
  logic [7:0] errorB = 8'h84, nRstB = 8'h00;
  logic [2:0] pendCode = 3'h5, cmdCode;
  logic pendValid = 1'b0, chanResetA, chanResetB, cmdStrobeA, cmdStrobeB;
  logic retIntCmd;
  int n_mismatch = 0, cmp_count = 0, ticks = 0;
  always #2 mclk = ~mclk;
  dcr_regs i_dcr_regs (
    .mclk(mclk), .sys_rst(sys_rst), .chipEnableN(chipEnableN),
    .readN(readN), .ioReqN(ioReqN), .chanSelB(chanSelB),
    .ctrlSel(ctrlSel), .dataIn(dataIn), .dataOut(dataOut),
    .dataOe(dataOe), .statusA(statusA), .statusB(statusB),
    .errorA(errorA), .errorB(errorB), .pendCode(pendCode),
    .pendValid(pendValid), .itmA(itmA), .itmB(itmB), .rxParA(rxParA),
    .rxParB(rxParB), .miscA(miscA), .miscB(miscB), .txParA(txParA),
    .txParB(txParB), .vectorReg(vectorReg), .chanResetA(chanResetA),
    .chanResetB(chanResetB), .cmdStrobeA(cmdStrobeA),
    .cmdStrobeB(cmdStrobeB), .cmdCode(cmdCode), .retIntCmd(retIntCmd)
  );
  dcr_host i_dcr_host (
    .mclk(mclk), .chipEnableN(chipEnableN), .readN(readN),
    .ioReqN(ioReqN), .chanSelB(chanSelB), .ctrlSel(ctrlSel),
    .dataIn(dataIn), .dataOut(dataOut)
  );
  // Compares one byte result and counts it.
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tally_and_finish();
    if (n_mismatch == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Counts command pulses and cuts a hang short.
  always @(posedge mclk) begin
    ticks <= ticks + 1;
    if (chanResetA === 1'b1) nRst <= nRst + 8'h01;
    if (retIntCmd === 1'b1) nRet <= nRet + 8'h01;
    if (chanResetB === 1'b1) nRstB <= nRstB + 8'h01;
    if (ticks == 5000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  // Reads a control register, sending its pointer byte first when nonzero.
  task automatic rd(input logic b, input logic [2:0] p, output logic [7:0] v);
    if (p != 3'h0) i_dcr_host.cyc(b, 1'b1, 1'b0, {5'h00, p}, v);
    i_dcr_host.cyc(b, 1'b1, 1'b1, 8'h00, v);
  endtask
  task automatic t_write();
    chk("itmA", 8'h00, itmA);
    i_dcr_host.wreg(1'b0, 3'h1, 8'hab);
    i_dcr_host.wreg(1'b1, 3'h2, 8'h5c);
    i_dcr_host.wreg(1'b0, 3'h2, 8'h77);
    i_dcr_host.wreg(1'b1, 3'h4, 8'h96);
    i_dcr_host.wreg(1'b0, 3'h3, 8'he1);
    i_dcr_host.wreg(1'b1, 3'h3, 8'h3c);
    i_dcr_host.wreg(1'b0, 3'h4, 8'h69);
    i_dcr_host.wreg(1'b1, 3'h5, 8'hd2);
    i_dcr_host.cyc(1'b0, 1'b0, 1'b0, 8'h44, q);
    chk("itmA", 8'hab, itmA);
    chk("vectorReg", 8'h5c, vectorReg);
    chk("miscB", 8'h96, miscB);
    chk("rxParA", 8'he1, rxParA);
    chk("rxParB", 8'h3c, rxParB);
    chk("miscA", 8'h69, miscA);
    chk("txParB", 8'hd2, txParB);
  endtask
  task automatic t_cmd();
    i_dcr_host.cyc(1'b0, 1'b1, 1'b0, 8'h1d, q);
    i_dcr_host.cyc(1'b0, 1'b1, 1'b0, 8'h07, q);
    i_dcr_host.cyc(1'b0, 1'b1, 1'b0, 8'h00, q);
    chk("txParA", 8'h00, txParA);
    chk("nRst", 8'h01, nRst);
    i_dcr_host.cyc(1'b0, 1'b1, 1'b0, 8'h38, q);
    i_dcr_host.cyc(1'b1, 1'b1, 1'b0, 8'h38, q);
    chk("nRet", 8'h01, nRet);
    chk("cmdCode", 8'h07, {5'h00, cmdCode});
    i_dcr_host.cyc(1'b1, 1'b1, 1'b0, 8'h18, q);
    chk("nRstB", 8'h01, nRstB);
    chk("nRst", 8'h01, nRst);
    chk("cmdCode", 8'h03, {5'h00, cmdCode});
  endtask
  task automatic t_read();
    rd(1'b0, 3'h0, q);
    chk("rr0A", 8'h5a, q);
    rd(1'b1, 3'h0, q);
    chk("rr0B", 8'hc3, q);
    rd(1'b0, 3'h1, q);
    chk("rr1A", 8'h21, q);
    rd(1'b1, 3'h1, q);
    chk("rr1B", 8'h84, q);
    rd(1'b1, 3'h2, q);
    chk("rr2B", 8'h5c, q);
    rd(1'b0, 3'h2, q);
    chk("rr2A", 8'h00, q);
    #1 pendValid = 1'b1;
    i_dcr_host.wreg(1'b1, 3'h1, 8'h04);
    rd(1'b1, 3'h2, q);
    chk("rr2mod", 8'h5a, q);
    #1 pendValid = 1'b0;
    rd(1'b1, 3'h2, q);
    chk("rr2none", 8'h56, q);
  endtask
  // A pin reset in mid-run drops a pending pointer to the transmit parameter register.
  task automatic t_reset();
    i_dcr_host.cyc(1'b0, 1'b1, 1'b0, 8'h05, q);
    #1 sys_rst = 1'b1;
    repeat (12) @(posedge mclk);
    #1 sys_rst = 1'b0;
    chk("itmA", 8'h00, itmA);
    i_dcr_host.cyc(1'b0, 1'b1, 1'b0, 8'h03, q);
    i_dcr_host.cyc(1'b0, 1'b1, 1'b0, 8'h11, q);
    chk("txParA", 8'h00, txParA);
    chk("rxParA", 8'h11, rxParA);
  endtask
  // Reset for twelve cycles, then the scenarios in programming order.
  initial begin
    repeat (12) @(posedge mclk);
    #1;
    sys_rst = 1'b0;
    t_write();
    t_cmd();
    t_read();
    t_reset();
    tally_and_finish();
  end
endmodule
